// ===== testbench/pbowb_sensor_model.sv
// sensor readout model feeding the pixel stage
`timescale 1ns/10ps
`default_nettype none
module pbowb_sensor_model (
  input wire logic clk_sys_i,
  output var pbowb_pkg::pbowb_pixel_t pix_o
);
  initial pix_o = '0;
  // one pixel per call, idle lines show the inverse
  task automatic send(input logic [1:0] col, input logic [11:0] val);
    @(posedge clk_sys_i);
    pix_o <= {1'b1, col, val};
    @(posedge clk_sys_i);
    pix_o <= {1'b0, ~col, ~val};
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_pbowb_stage.sv
// self-checking bench for the pixel stage
`timescale 1ns/10ps
`default_nettype none
module tb_pbowb_stage;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  pbowb_pkg::pbowb_pixel_t pix_i;
  pbowb_pkg::pbowb_pixel_t pix_o;
  int err_count = 0;
  int tests_run = 0;
  int cv[6] = '{0, 0, 1, 1, 2, 2};
  int cd[6] = '{0, 1, 0, 1, 0, 1};
  int st[6] = '{16, 1, 4, 4, 64, 4};
  int mx[3] = '{255, 64, 1023};
  int rat[3] = '{192, 64, 511};
  int rrd[3] = '{192, 64, 510};
  int rpx[3] = '{150, 50, 255};
  int b[4];
  always #20 clk_sys_i = ~clk_sys_i;
  pbowb_sensor_model src (.clk_sys_i(clk_sys_i), .pix_o(pix_i));
  pbowb_stage dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pix_i(pix_i), .pix_o(pix_o));
  // ****************************************
  // tasks
  // ****************************************
  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pix(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input int d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= 16'(d);
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input int e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    cmp_reg(rdata_o, 16'(e));
  endtask
  task automatic pix(input logic [1:0] c, input int v, input int e);
    src.send(c, 12'(v));
    @(posedge clk_sys_i);
    #1;
    cmp_pix({pix_o.valid, pix_o.value}, {1'b1, 12'(e)});
    @(posedge clk_sys_i);
    #1;
    cmp_pix({pix_o.valid, 12'h000}, 13'h0000);
  endtask
  // expected output from offset and saturation, no ratio scaling
  function automatic int model(input int vr, input int d12, input int blk, input int v);
    int lim;
    int sh;
    int s;
    lim = d12 ? 4095 : 255;
    sh = (vr == 1) ? 2 : (vr == 0) ? (d12 ? 0 : 4) : (d12 ? 2 : 6);
    s = v + ((blk - mx[vr] / 2) >>> sh);
    return (s < 0) ? 0 : (s > lim) ? lim : s;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    #2ms;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(pbowb_pkg::ADDR_CTRL, 0);
    rd(pbowb_pkg::ADDR_BLACK_LEVEL, 0);
    rd(pbowb_pkg::ADDR_RATIO_VAL, 128);
    rd(4'hf, 0);
    for (int k = 0; k < 6; k++) begin
      wr(pbowb_pkg::ADDR_CTRL, cv[k] + 4 * cd[k]);
      wr(pbowb_pkg::ADDR_BLACK_LEVEL, 1023);
      rd(pbowb_pkg::ADDR_BLACK_LEVEL, mx[cv[k]]);
      b = '{0, mx[cv[k]], mx[cv[k]] / 2 + st[k] - 1, mx[cv[k]] / 2 + st[k]};
      for (int j = 0; j < 4; j++) begin
        wr(pbowb_pkg::ADDR_BLACK_LEVEL, b[j]);
        pix(2'h1, 100, model(cv[k], cd[k], b[j], 100));
        pix(2'h0, (j == 1) ? 4090 >> (4 - 4 * cd[k]) : 2, model(cv[k], cd[k], b[j],
          (j == 1) ? 4090 >> (4 - 4 * cd[k]) : 2));
      end
    end
    wr(pbowb_pkg::ADDR_BLACK_SEL, 1);
    wr(pbowb_pkg::ADDR_BLACK_LEVEL, 5);
    rd(pbowb_pkg::ADDR_BLACK_LEVEL, 515);
    wr(pbowb_pkg::ADDR_BLACK_SEL, 0);
    wr(pbowb_pkg::ADDR_CTRL, 8);
    wr(pbowb_pkg::ADDR_BLACK_LEVEL, 127);
    for (int c = 0; c < 3; c++) begin
      wr(pbowb_pkg::ADDR_RATIO_SEL, c);
      wr(pbowb_pkg::ADDR_RATIO_VAL, rat[c]);
      rd(pbowb_pkg::ADDR_RATIO_VAL, rrd[c]);
    end
    wr(pbowb_pkg::ADDR_RATIO_SEL, 3);
    rd(pbowb_pkg::ADDR_RATIO_SEL, 2);
    for (int c = 0; c < 3; c++) begin
      pix(2'(c), 100, rpx[c]);
    end
    wr(pbowb_pkg::ADDR_RATIO_SEL, 1);
    wr(pbowb_pkg::ADDR_RATIO_VAL, 0);
    pix(2'h1, 100, 0);
    pix(2'h0, 100, 150);
    wr(pbowb_pkg::ADDR_CTRL, 0);
    pix(2'h0, 100, 100);
    rd(pbowb_pkg::ADDR_STATUS, 255);
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== verilog/pbowb_pkg.sv
// package of constants and types for the black offset and white balance stage
package pbowb_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BLACK_SEL = 4'h1;
  localparam logic [3:0] ADDR_BLACK_LEVEL = 4'h2;
  localparam logic [3:0] ADDR_RATIO_SEL = 4'h3;
  localparam logic [3:0] ADDR_RATIO_VAL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_VARIANT_LSB = 0;
  localparam int CTRL_DEPTH12_BIT = 2;
  localparam int CTRL_COLOUR_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] BLACK_SEL_ALL = 2'h0;
  localparam logic [9:0] BLACK_RESET = 10'h000;
  // ratio fixed point, 2 integer bits and 7 fraction bits
  localparam int RATIO_FRAC = 7;
  localparam logic [8:0] RATIO_ONE = 9'h080;
  localparam logic [8:0] RATIO_MAX = 9'h1fe;
  localparam logic [9:0] MAX_STD = 10'h0ff;
  localparam logic [9:0] MAX_FAST = 10'h040;
  localparam logic [9:0] MAX_WIDE = 10'h3ff;
  localparam logic [11:0] PIX_MAX8 = 12'h0ff;
  localparam logic [11:0] PIX_MAX12 = 12'hfff;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    VAR_STD,
    VAR_FAST,
    VAR_WIDE
  } pbowb_variant_t;

  typedef enum logic [1:0] {
    COL_RED,
    COL_GREEN,
    COL_BLUE
  } pbowb_colour_t;

  typedef struct packed {
    logic valid;
    pbowb_colour_t colour;
    logic [11:0] value;
  } pbowb_pixel_t;

endpackage

// ===== verilog/pbowb_stage.sv
// black level offset and white balance pixel stage
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - add signed offset from black setting to each pixel; larger setting more positive
// - standard variant, 8-bit depth: 16 setting steps per output code
// - standard variant, 12-bit depth: 1 setting step per output code
// - fast variant: 4 setting steps per code, any format
// - wide variant, 8-bit depth: 64 setting steps per code
// - wide variant, 12-bit depth: 4 setting steps per code
// - standard variant accepts settings 0 to 255
// - fast variant accepts settings 0 to 64
// - wide variant accepts settings 0 to 1023
// - separate red, green, blue ratios; ratio one leaves intensity unchanged
// - pixel scaled proportionally by its colour ratio
// - ratios from 0.00 to 3.98 accepted
// - monochrome passes pixels with no ratio scaling
module pbowb_stage (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire pbowb_pkg::pbowb_pixel_t pix_i,
  output pbowb_pkg::pbowb_pixel_t pix_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [9:0] clamp_set(input logic [9:0] v, input logic [9:0] lim);
    clamp_set = (v > lim) ? lim : v;
  endfunction

  function automatic logic [11:0] sat(input logic signed [22:0] v, input logic [11:0] lim);
    if (v < 0) begin
      sat = 12'h000;
    end else if (v > $signed({11'h000, lim})) begin
      sat = lim;
    end else begin
      sat = v[11:0];
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [3:0] ctrl_q;
  logic [1:0] black_sel_q;
  logic [9:0] black_q;
  logic [1:0] ratio_sel_q;
  logic [8:0] ratio_q [3];
  logic [15:0] rdata_q;
  pbowb_pkg::pbowb_pixel_t mid_q;
  pbowb_pkg::pbowb_pixel_t out_q;

  wire pbowb_pkg::pbowb_variant_t variant = pbowb_pkg::pbowb_variant_t'(ctrl_q[pbowb_pkg::CTRL_VARIANT_LSB +: 2]);
  wire depth12 = ctrl_q[pbowb_pkg::CTRL_DEPTH12_BIT];
  wire colour_en = ctrl_q[pbowb_pkg::CTRL_COLOUR_BIT];
  wire [11:0] pix_max = depth12 ? pbowb_pkg::PIX_MAX12 : pbowb_pkg::PIX_MAX8;

  // setting range per variant
  wire [9:0] set_lim = (variant == pbowb_pkg::VAR_FAST) ? pbowb_pkg::MAX_FAST
                     : (variant == pbowb_pkg::VAR_WIDE) ? pbowb_pkg::MAX_WIDE
                     : pbowb_pkg::MAX_STD;
  wire [9:0] wr_black = clamp_set(wdata_i[9:0], set_lim);
  wire [8:0] wr_ratio = (wdata_i[8:0] > pbowb_pkg::RATIO_MAX) ? pbowb_pkg::RATIO_MAX : wdata_i[8:0];

  // ****************************************
  // decode
  // ****************************************
  wire wr_ctrl = wr_i && (addr_i == pbowb_pkg::ADDR_CTRL);
  wire wr_bsel = wr_i && (addr_i == pbowb_pkg::ADDR_BLACK_SEL);
  wire wr_blk = wr_i && (addr_i == pbowb_pkg::ADDR_BLACK_LEVEL) && (black_sel_q == pbowb_pkg::BLACK_SEL_ALL);
  wire wr_rsel = wr_i && (addr_i == pbowb_pkg::ADDR_RATIO_SEL) && (wdata_i[1:0] != 2'h3);
  wire wr_rat = wr_i && (addr_i == pbowb_pkg::ADDR_RATIO_VAL);
  logic [15:0] rd_mux;
  always_comb begin
    if (addr_i == pbowb_pkg::ADDR_CTRL) begin
      rd_mux = {12'h000, ctrl_q};
    end else if (addr_i == pbowb_pkg::ADDR_BLACK_SEL) begin
      rd_mux = {14'h0000, black_sel_q};
    end else if (addr_i == pbowb_pkg::ADDR_BLACK_LEVEL) begin
      rd_mux = {6'h00, black_q};
    end else if (addr_i == pbowb_pkg::ADDR_RATIO_SEL) begin
      rd_mux = {14'h0000, ratio_sel_q};
    end else if (addr_i == pbowb_pkg::ADDR_RATIO_VAL) begin
      rd_mux = {7'h00, ratio_q[ratio_sel_q]};
    end else if (addr_i == pbowb_pkg::ADDR_STATUS) begin
      rd_mux = {3'h0, out_q.valid, out_q.value};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ctrl_q <= pbowb_pkg::CTRL_RESET;
      black_sel_q <= pbowb_pkg::BLACK_SEL_ALL;
      black_q <= pbowb_pkg::BLACK_RESET;
      ratio_sel_q <= 2'h0;
      rdata_q <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= (wdata_i[1:0] == 2'h3) ? {wdata_i[3:2], 2'h0} : wdata_i[3:0];
      end
      if (wr_bsel) begin
        black_sel_q <= wdata_i[1:0];
      end
      if (wr_blk) begin
        black_q <= wr_black;
      end else if (black_q > set_lim) begin
        black_q <= set_lim;
      end
      if (wr_rsel) begin
        ratio_sel_q <= wdata_i[1:0];
      end
      rdata_q <= rd_i ? rd_mux : 16'h0000;
    end
  end

  // one ratio per colour, only the selected one written
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < 3; i++) begin
      if (!reset_n_i) begin
        ratio_q[i] <= pbowb_pkg::RATIO_ONE;
      end else if (wr_rat && (ratio_sel_q == 2'(i))) begin
        ratio_q[i] <= wr_ratio;
      end
    end
  end

  assign rdata_o = rdata_q;

  // ****************************************
  // black offset, setting minus midpoint scaled per variant and depth
  // ****************************************
  wire signed [11:0] centred = $signed({2'b00, black_q}) - $signed({2'b00, set_lim >> 1});
  logic signed [11:0] offset;
  always_comb begin
    case (variant)
      pbowb_pkg::VAR_FAST: offset = centred >>> 2;
      pbowb_pkg::VAR_WIDE: offset = depth12 ? (centred >>> 2) : (centred >>> 6);
      default: offset = depth12 ? centred : (centred >>> 4);
    endcase
  end

  wire signed [22:0] offs_sum = 23'($signed({1'b0, pix_i.value})) + 23'(offset);
  wire [11:0] offs_pix = sat(offs_sum, pix_max);

  // ****************************************
  // white balance, one multiply
  // ****************************************
  // unused colour code passes at unity gain
  wire [8:0] gain = (mid_q.colour == 2'h3) ? pbowb_pkg::RATIO_ONE : ratio_q[mid_q.colour];
  wire [20:0] prod = mid_q.value * gain;
  wire [11:0] wb_pix = sat(23'(prod >> pbowb_pkg::RATIO_FRAC), pix_max);

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mid_q <= '0;
      out_q <= '0;
    end else begin
      mid_q <= '{valid: pix_i.valid, colour: pix_i.colour, value: offs_pix};
      out_q <= '{valid: mid_q.valid, colour: mid_q.colour, value: colour_en ? wb_pix : mid_q.value};
    end
  end

  assign pix_o = out_q;

  // ****************************************
  // checks
  // ****************************************
  chk_mono_passthru: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !colour_en && mid_q.valid |=> out_q.value == $past(mid_q.value))
    else $error("mono pixel altered");
  chk_ratio_unity: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    colour_en && gain == pbowb_pkg::RATIO_ONE && $stable(ctrl_q) |=> out_q.value == $past(mid_q.value))
    else $error("unity ratio changed pixel");
  chk_out_depth: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !depth12 ##1 $stable(ctrl_q) |=> out_q.value <= pbowb_pkg::PIX_MAX8)
    else $error("pixel exceeds 8-bit depth");
  chk_ratio_max: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_rat |=> ratio_q[$past(ratio_sel_q)] <= pbowb_pkg::RATIO_MAX)
    else $error("ratio above limit");
  chk_black_sel: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_i && addr_i == pbowb_pkg::ADDR_BLACK_LEVEL && black_sel_q != pbowb_pkg::BLACK_SEL_ALL
    && black_q <= set_lim && $stable(ctrl_q) |=> $stable(black_q))
    else $error("black written without all select");
  chk_black_fast: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_FAST ##1 variant == pbowb_pkg::VAR_FAST |-> black_q <= pbowb_pkg::MAX_FAST)
    else $error("fast setting out of range");
  chk_black_std: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_STD ##1 variant == pbowb_pkg::VAR_STD |-> black_q <= pbowb_pkg::MAX_STD)
    else $error("std setting out of range");
  chk_pipe_valid: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    pix_i.valid |-> ##2 out_q.valid)
    else $error("pixel lost");
  chk_ratio_sel: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_rat && ratio_sel_q != 2'h0 |=> $stable(ratio_q[0]))
    else $error("unselected ratio changed");

  // ****************************************
  // offset checks
  // ****************************************
  chk_offset_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    black_q == (set_lim >> 1) && pix_i.value <= pix_max
    |=> mid_q.value == $past(pix_i.value))
    else $error("offset not zero at midpoint");
  chk_offset_up: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    black_q > (set_lim >> 1) && pix_i.value <= pix_max
    |=> mid_q.value >= $past(pix_i.value))
    else $error("high setting lowered pixel");
  chk_offset_down: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    black_q < (set_lim >> 1)
    |=> mid_q.value <= $past(pix_i.value))
    else $error("low setting raised pixel");
  chk_std8_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_STD && !depth12 && black_q == 10'h08f
    |-> offset == 12'sh001)
    else $error("std 8-bit step not one code");
  chk_std8_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_STD && !depth12 && black_q == 10'h08e
    |-> offset == 12'sh000)
    else $error("std 8-bit step too fine");
  chk_std12_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_STD && depth12 && black_q == 10'h080
    |-> offset == 12'sh001)
    else $error("std 12-bit step not one code");
  chk_std12_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_STD && depth12 && black_q == 10'h07f
    |-> offset == 12'sh000)
    else $error("std 12-bit midpoint not zero");
  chk_fast8_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_FAST && !depth12 && black_q == 10'h024
    |-> offset == 12'sh001)
    else $error("fast 8-bit step not one code");
  chk_fast12_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_FAST && depth12 && black_q == 10'h024
    |-> offset == 12'sh001)
    else $error("fast 12-bit step not one code");
  chk_fast_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_FAST && black_q == 10'h023
    |-> offset == 12'sh000)
    else $error("fast step too fine");
  chk_wide8_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_WIDE && !depth12 && black_q == 10'h23f
    |-> offset == 12'sh001)
    else $error("wide 8-bit step not one code");
  chk_wide8_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_WIDE && !depth12 && black_q == 10'h23e
    |-> offset == 12'sh000)
    else $error("wide 8-bit step too fine");
  chk_wide12_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_WIDE && depth12 && black_q == 10'h203
    |-> offset == 12'sh001)
    else $error("wide 12-bit step not one code");
  chk_wide12_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    variant == pbowb_pkg::VAR_WIDE && depth12 && black_q == 10'h202
    |-> offset == 12'sh000)
    else $error("wide 12-bit step too fine");
  chk_black_std_acc: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_blk && variant == pbowb_pkg::VAR_STD && wdata_i[9:0] <= pbowb_pkg::MAX_STD
    |=> black_q == $past(wdata_i[9:0]))
    else $error("std setting in range refused");
  chk_black_fast_acc: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_blk && variant == pbowb_pkg::VAR_FAST && wdata_i[9:0] <= pbowb_pkg::MAX_FAST
    |=> black_q == $past(wdata_i[9:0]))
    else $error("fast setting in range refused");
  chk_black_wide_acc: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_blk && variant == pbowb_pkg::VAR_WIDE && wdata_i[9:0] <= pbowb_pkg::MAX_WIDE
    |=> black_q == $past(wdata_i[9:0]))
    else $error("wide setting in range refused");

  // ****************************************
  // ratio checks
  // ****************************************
  chk_ratio_up: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    colour_en && $stable(ctrl_q) && gain > pbowb_pkg::RATIO_ONE
    |=> out_q.value >= $past(mid_q.value))
    else $error("ratio above one lowered pixel");
  chk_ratio_down: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    colour_en && $stable(ctrl_q) && gain < pbowb_pkg::RATIO_ONE
    |=> out_q.value <= $past(mid_q.value))
    else $error("ratio below one raised pixel");
  chk_ratio_accept: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_rat && wdata_i[8:0] <= pbowb_pkg::RATIO_MAX
    |=> ratio_q[$past(ratio_sel_q)] == $past(wdata_i[8:0]))
    else $error("ratio in range refused");
  chk_ratio_sel_blue: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_rat && ratio_sel_q != 2'h2
    |=> $stable(ratio_q[2]))
    else $error("unselected blue ratio changed");

endmodule
`default_nettype wire
